// ### rtl/vddc_defines.vh
// Constants for the display channel control decoder
`ifndef VDDC_DEFINES_VH
`define VDDC_DEFINES_VH
// ==========================================================
// Register map (byte addresses)
`define VDDC_CTRL_ADDR 12'h000
`define VDDC_STAT_ADDR 12'h004
`define VDDC_ADDR_W 12
// ==========================================================
// Field positions of display_channel_control
`define VDDC_BIT_CHRST 31
`define VDDC_BIT_BLKDIS 30
`define VDDC_BIT_EN 15
`define VDDC_BIT_DPK 14
`define VDDC_BIT_RGB_EXTRACT_EN 13
`define VDDC_BIT_SECOND_RAW_CHANNEL_EN 12
`define VDDC_BIT_DVAL 11
`define VDDC_BIT_CHROMA_RESAMPLE_EN 10
`define VDDC_BIT_RSV9 9
`define VDDC_BIT_SCALE 8
`define VDDC_BIT_CONT 7
`define VDDC_BIT_FRAME 6
`define VDDC_BIT_FLD2 5
`define VDDC_BIT_FLD1 4
`define VDDC_BIT_RSV3 3
`define VDDC_MODE_HI 2
`define VDDC_MODE_LO 0
// Writable bits of the control word; reserved bits 9 and 3 excluded
`define VDDC_CTRL_WMASK 32'hc000_fdf7
`define VDDC_LOCK_MASK 32'h0000_7df7
`define VDDC_CTRL_RESET 32'h0000_0000
// ==========================================================
// Display mode codes
`define VDDC_MODE_BT8 3'h0
`define VDDC_MODE_BT10 3'h1
`define VDDC_MODE_RAW8 3'h2
`define VDDC_MODE_RAW10 3'h3
`define VDDC_MODE_YC8 3'h4
`define VDDC_MODE_YC10 3'h5
`define VDDC_MODE_RAW16 3'h6
`define VDDC_MODE_RAW20 3'h7
// Raw widths
`define VDDC_RAWW_8 2'h0
`define VDDC_RAWW_10 2'h1
`define VDDC_RAWW_16 2'h2
`define VDDC_RAWW_20 2'h3
`endif

// ### rtl/vddc_mode_decode.v
// Display mode field decoder
`timescale 1ns/10ps
`include "vddc_defines.vh"
module vddc_mode_decode (
  input wire [2:0] i_mode,
  output reg o_is_bt656,
  output reg o_is_yc,
  output reg o_is_raw,
  output reg o_ten_bit,
  output reg [1:0] o_raw_width
);
  always @* begin
    o_is_bt656 = 1'b0;
    o_is_yc = 1'b0;
    o_is_raw = 1'b0;
    o_ten_bit = 1'b0;
    o_raw_width = `VDDC_RAWW_8;
    case (i_mode)
      `VDDC_MODE_BT8: begin
        o_is_bt656 = 1'b1;
      end
      `VDDC_MODE_BT10: begin
        o_is_bt656 = 1'b1;
        o_ten_bit = 1'b1;
      end
      `VDDC_MODE_YC8: begin
        o_is_yc = 1'b1;
      end
      `VDDC_MODE_YC10: begin
        o_is_yc = 1'b1;
        o_ten_bit = 1'b1;
      end
      `VDDC_MODE_RAW8: begin
        o_is_raw = 1'b1;
      end
      `VDDC_MODE_RAW10: begin
        o_is_raw = 1'b1;
        o_ten_bit = 1'b1;
        o_raw_width = `VDDC_RAWW_10;
      end
      `VDDC_MODE_RAW16: begin
        o_is_raw = 1'b1;
        o_raw_width = `VDDC_RAWW_16;
      end
      `VDDC_MODE_RAW20: begin
        o_is_raw = 1'b1;
        o_ten_bit = 1'b1;
        o_raw_width = `VDDC_RAWW_20;
      end
      default: begin
        o_is_bt656 = 1'b1;
      end
    endcase
  end
endmodule // vddc_mode_decode

// ### rtl/vddc_gate.v
// Registered control bit gated by a mode class
`timescale 1ns/10ps
module vddc_gate (
  input wire i_mclk,
  input wire i_reset,
  input wire i_bit,
  input wire i_class_ok,
  output reg o_q
);
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_q <= 1'b0;
    end else begin
      o_q <= i_bit & i_class_ok;
    end
  end
endmodule // vddc_gate

// ### rtl/vddc_top.v
// Display channel control register and decode, APB slave
//
// Implementation choices: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
`include "vddc_defines.vh"
module vddc_top (
  input wire i_mclk,
  input wire i_reset,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output wire o_pready,
  output reg [31:0] o_prdata,
  output wire o_pslverr,
  output wire o_display_channel_en,
  output wire o_channel_reset,
  output wire o_blank_disable,
  output wire o_dense_unpack,
  output reg [2:0] o_display_mode_sel,
  output reg o_mode_bt656,
  output reg o_mode_yc,
  output reg o_mode_raw,
  output reg o_ten_bit,
  output reg [1:0] o_raw_width,
  output wire o_rgb_extract_en,
  output wire o_second_raw_channel_en,
  output wire o_default_value_sel,
  output wire o_chroma_resample_en,
  output wire o_scale_x2,
  output reg o_continuous_display_en,
  output reg o_show_frame_code,
  output reg o_show_second_field,
  output reg o_show_first_field,
  output reg o_locked_write_q
);
  // ==========================================================
  // Bus decode
  reg [31:0] ctrl_q;
  reg [31:0] ctrl_d;
  reg locked_d;
  wire access;
  wire wr;
  wire hit_ctrl;
  wire hit_stat;
  wire chg_locked;
  wire dec_bt;
  wire dec_yc;
  wire dec_raw;
  wire dec_ten;
  wire [1:0] dec_rw;
  wire vid_class;

  assign access = i_psel & i_penable;
  assign wr = access & i_pwrite;
  assign hit_ctrl = (i_paddr == `VDDC_CTRL_ADDR);
  assign hit_stat = (i_paddr == `VDDC_STAT_ADDR);
  // Zero wait states; unmapped addresses answer with an error
  assign o_pready = 1'b1;
  assign o_pslverr = access & ~(hit_ctrl | hit_stat);

  // ==========================================================
  // Control register
  // A write that alters locked fields while enabled is still applied;
  // hardware only flags it, since the interlock is a software duty
  assign chg_locked = ((i_pwdata ^ ctrl_q) & `VDDC_LOCK_MASK) != 32'h0000_0000;

  always @* begin
    ctrl_d = ctrl_q;
    locked_d = o_locked_write_q;
    // Channel reset is a self-clearing strobe
    ctrl_d[`VDDC_BIT_CHRST] = 1'b0;
    if (wr & hit_ctrl) begin
      ctrl_d = i_pwdata & `VDDC_CTRL_WMASK;
      if (ctrl_q[`VDDC_BIT_EN] & chg_locked) begin
        locked_d = 1'b1;
      end
    end
    if (wr & hit_stat & i_pwdata[0]) begin
      locked_d = 1'b0;
    end
  end

  always @(posedge i_mclk) begin
    if (i_reset) begin
      ctrl_q <= `VDDC_CTRL_RESET;
      o_locked_write_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      o_locked_write_q <= locked_d;
    end
  end

  // ==========================================================
  // Read data
  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_prdata <= 32'h0000_0000;
    end else if (i_psel & ~i_penable & ~i_pwrite) begin
      if (i_paddr == `VDDC_CTRL_ADDR) begin
        o_prdata <= ctrl_q & `VDDC_CTRL_WMASK;
      end else if (i_paddr == `VDDC_STAT_ADDR) begin
        o_prdata <= {26'h0, o_raw_width, o_ten_bit, o_mode_raw, o_mode_yc,
                     o_locked_write_q};
      end else begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end

  // ==========================================================
  // Mode decode
  vddc_mode_decode u_mode (
    .i_mode(ctrl_q[`VDDC_MODE_HI:`VDDC_MODE_LO]),
    .o_is_bt656(dec_bt),
    .o_is_yc(dec_yc),
    .o_is_raw(dec_raw),
    .o_ten_bit(dec_ten),
    .o_raw_width(dec_rw)
  );

  assign vid_class = dec_bt | dec_yc;

  always @(posedge i_mclk) begin
    if (i_reset) begin
      o_display_mode_sel <= `VDDC_MODE_BT8;
      o_mode_bt656 <= 1'b1;
      o_mode_yc <= 1'b0;
      o_mode_raw <= 1'b0;
      o_ten_bit <= 1'b0;
      o_raw_width <= `VDDC_RAWW_8;
      o_continuous_display_en <= 1'b0;
      o_show_frame_code <= 1'b0;
      o_show_second_field <= 1'b0;
      o_show_first_field <= 1'b0;
    end else begin
      o_display_mode_sel <= ctrl_q[`VDDC_MODE_HI:`VDDC_MODE_LO];
      o_mode_bt656 <= dec_bt;
      o_mode_yc <= dec_yc;
      o_mode_raw <= dec_raw;
      o_ten_bit <= dec_ten;
      o_raw_width <= dec_rw & {2{dec_raw}};
      o_continuous_display_en <= ctrl_q[`VDDC_BIT_CONT];
      o_show_frame_code <= ctrl_q[`VDDC_BIT_FRAME];
      o_show_second_field <= ctrl_q[`VDDC_BIT_FLD2];
      o_show_first_field <= ctrl_q[`VDDC_BIT_FLD1];
    end
  end

  // ==========================================================
  // Mode gated options
  vddc_gate u_rgb_extract_en (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_bit(ctrl_q[`VDDC_BIT_RGB_EXTRACT_EN]),
    .i_class_ok(dec_raw),
    .o_q(o_rgb_extract_en)
  );

  vddc_gate u_second_raw_channel_en (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_bit(ctrl_q[`VDDC_BIT_SECOND_RAW_CHANNEL_EN]),
    .i_class_ok(dec_raw),
    .o_q(o_second_raw_channel_en)
  );

  vddc_gate u_dval (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_bit(ctrl_q[`VDDC_BIT_DVAL]),
    .i_class_ok(vid_class),
    .o_q(o_default_value_sel)
  );

  vddc_gate u_chroma_resample_en (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_bit(ctrl_q[`VDDC_BIT_CHROMA_RESAMPLE_EN]),
    .i_class_ok(vid_class),
    .o_q(o_chroma_resample_en)
  );

  vddc_gate u_scale (
    .i_mclk(i_mclk),
    .i_reset(i_reset),
    .i_bit(ctrl_q[`VDDC_BIT_SCALE]),
    .i_class_ok(vid_class),
    .o_q(o_scale_x2)
  );

  // Upper bits pass through unconditioned; all but DPK (bit 14) are exempt from the interlock
  assign o_display_channel_en = ctrl_q[`VDDC_BIT_EN];
  assign o_channel_reset = ctrl_q[`VDDC_BIT_CHRST];
  assign o_blank_disable = ctrl_q[`VDDC_BIT_BLKDIS];
  assign o_dense_unpack = ctrl_q[`VDDC_BIT_DPK];
endmodule // vddc_top

// ### bench/vddc_props.sv
// Concurrent checks on the control decoder ports
`timescale 1ns/10ps
module vddc_props (
  input logic i_mclk,
  input logic i_reset,
  input logic i_psel,
  input logic i_penable,
  input logic i_pwrite,
  input logic [11:0] i_paddr,
  input logic [31:0] i_pwdata,
  input logic [31:0] o_prdata,
  input logic [2:0] o_display_mode_sel,
  input logic o_mode_bt656,
  input logic o_mode_yc,
  input logic o_mode_raw,
  input logic [1:0] o_raw_width,
  input logic o_rgb_extract_en,
  input logic o_second_raw_channel_en,
  input logic o_default_value_sel,
  input logic o_chroma_resample_en,
  input logic o_scale_x2
);
  // ==========================================================
  // Clocking
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  // Decode lags the write by two edges, so $past depth is 2
  wire wr = i_psel && i_penable && i_pwrite && i_paddr == 12'h000;
  wire rd = i_psel && i_penable && !i_pwrite && i_paddr == 12'h000;
  // ==========================================================
  // Properties
  a_rgb_extract_en_raw_only: assert property (o_rgb_extract_en |-> o_mode_raw)
    else $error("rgb extract outside raw mode");
  a_second_raw_channel_en_raw_only: assert property (o_second_raw_channel_en |-> o_mode_raw)
    else $error("second channel outside raw mode");
  a_dval_not_raw: assert property (o_default_value_sel |-> !o_mode_raw)
    else $error("default value in raw mode");
  a_chroma_resample_en_not_raw: assert property ((o_chroma_resample_en || o_scale_x2) |-> !o_mode_raw)
    else $error("resample or scale in raw mode");
  a_rsv_read_zero: assert property (rd |-> o_prdata[9] == 1'b0 && o_prdata[3] == 1'b0)
    else $error("reserved bit read nonzero");
  a_mode_follows: assert property (wr |-> ##2 o_display_mode_sel == $past(i_pwdata[2:0], 2))
    else $error("mode select did not follow write");
  a_bt_yc_class: assert property (o_mode_bt656 == (o_display_mode_sel[2:1] == 2'h0)
    && o_mode_yc == (o_display_mode_sel[2:1] == 2'h2))
    else $error("mode class wrong");
  a_raw_width_map: assert property (o_mode_raw |-> o_mode_raw == o_display_mode_sel[1]
    && o_raw_width == {o_display_mode_sel[2], o_display_mode_sel[0]})
    else $error("raw width wrong");
endmodule // vddc_props
bind vddc_top vddc_props vddc_props_i (.i_mclk, .i_reset, .i_psel, .i_penable, .i_pwrite,
  .i_paddr, .i_pwdata, .o_prdata, .o_display_mode_sel, .o_mode_bt656, .o_mode_yc, .o_mode_raw,
  .o_raw_width, .o_rgb_extract_en, .o_second_raw_channel_en, .o_default_value_sel,
  .o_chroma_resample_en, .o_scale_x2);

// ### bench/video_display_control_decode_test.sv
// Register-level bench for the control decoder
`timescale 1ns/10ps
module video_display_control_decode_test;
  logic i_mclk, i_reset, i_psel, i_penable, i_pwrite;
  logic [11:0] i_paddr;
  logic [31:0] i_pwdata;
  wire o_pready, o_pslverr, o_mode_bt656, o_mode_yc, o_mode_raw;
  wire [31:0] o_prdata;
  wire [2:0] o_display_mode_sel;
  wire [1:0] o_raw_width;
  wire o_rgb_extract_en, o_second_raw_channel_en, o_default_value_sel;
  wire o_chroma_resample_en, o_scale_x2, o_continuous_display_en;
  wire o_show_frame_code, o_show_second_field, o_show_first_field;
  wire o_ten_bit, o_display_channel_en, o_channel_reset, o_blank_disable;
  wire o_dense_unpack, o_locked_write_q;
  integer fail_count = 0, n_checks = 0, i;
  logic [31:0] rd;
  logic err;
  // Options set in every mode, reserved bits 9 and 3 set too; bit 15 kept clear
  logic [31:0] tv [0:13] = '{32'h3ff8, 32'h3ff9, 32'h3ffa, 32'h3ffb, 32'h3ffc, 32'h3ffd,
    32'h3ffe, 32'h3fff, 32'h0080, 32'h0040, 32'h0020, 32'h0010, 32'h0d06, 32'h2003};
  vddc_top vddc_top_i (.i_mclk, .i_reset, .i_psel, .i_penable, .i_pwrite, .i_paddr,
    .i_pwdata, .o_pready, .o_prdata, .o_pslverr, .o_display_channel_en,
    .o_channel_reset, .o_blank_disable, .o_dense_unpack, .o_display_mode_sel,
    .o_mode_bt656, .o_mode_yc, .o_mode_raw, .o_ten_bit, .o_raw_width, .o_rgb_extract_en,
    .o_second_raw_channel_en, .o_default_value_sel, .o_chroma_resample_en, .o_scale_x2,
    .o_continuous_display_en, .o_show_frame_code, .o_show_second_field,
    .o_show_first_field, .o_locked_write_q);
  initial begin
    i_mclk = 0;
    forever #20 i_mclk = ~i_mclk;
  end
  // ==========================================================
  // Tasks
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      n_checks++;
      if (g !== e) begin
        $display("unexpected %s exp %h got %h", nm, e, g);
        fail_count++;
      end
    end
  endtask
  // One idle edge first, so a strobe never changes twice in one step
  task apb(input w, input [11:0] a, input [31:0] wd);
    integer n;
    begin
      @(posedge i_mclk);
      i_psel <= 1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= wd;
      @(posedge i_mclk);
      i_penable <= 1;
      n = 0;
      do begin
        @(posedge i_mclk);
        n++;
      end while (o_pready !== 1'b1 && n < 20);
      if (n >= 20) begin
        fail_count++;
        stop_test;
      end
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 0;
      i_penable <= 0;
    end
  endtask
  // Raw modes are exactly the codes with bit 1 set
  function [31:0] exp_dec(input [31:0] d);
    logic r;
    begin
      r = d[1];
      exp_dec = {d[2:0], d[2:1] == 2'h0, d[2:1] == 2'h2, r, r ? {d[2], d[0]} : 2'h0,
        d[13] & r, d[12] & r, d[11] & ~r, d[10] & ~r, d[8] & ~r, d[7:4]};
    end
  endfunction
  wire [31:0] dec = {o_display_mode_sel, o_mode_bt656, o_mode_yc, o_mode_raw, o_raw_width,
    o_rgb_extract_en, o_second_raw_channel_en, o_default_value_sel, o_chroma_resample_en,
    o_scale_x2, o_continuous_display_en, o_show_frame_code, o_show_second_field,
    o_show_first_field};
  // ==========================================================
  // Sequence
  initial begin
    i_reset = 1;
    i_psel = 0;
    i_penable = 0;
    i_pwrite = 0;
    i_paddr = 0;
    i_pwdata = 0;
    repeat (10) @(posedge i_mclk);
    i_reset <= 0;
    apb(0, 12'h000, 0);
    chk("ctrl reset", 0, rd);
    chk("decode reset", exp_dec(0), dec);
    $display("test reset done");
    for (i = 0; i < 14; i++) begin
      apb(1, 12'h000, tv[i]);
      apb(0, 12'h000, 0);
      chk("ctrl readback", tv[i] & 32'h3df7, rd);
      chk("decode", exp_dec(tv[i]), dec);
    end
    $display("test modes done");
    apb(1, 12'h00c, 32'h00ff);
    chk("unmapped write err", 1, err);
    apb(0, 12'h008, 0);
    chk("unmapped read err", 1, err);
    chk("unmapped read data", 0, rd);
    apb(0, 12'h000, 0);
    chk("ctrl kept", tv[13] & 32'h3df7, rd);
    $display("test unmapped done");
    apb(1, 12'h000, 32'h4000_c000);
    @(negedge i_mclk);
    chk("enable", 1, o_display_channel_en);
    chk("dense unpack", 1, o_dense_unpack);
    chk("blank disable", 1, o_blank_disable);
    apb(1, 12'h000, 32'h8000_c001);
    @(negedge i_mclk);
    chk("channel reset", 1, o_channel_reset);
    chk("locked flag", 1, o_locked_write_q);
    @(negedge i_mclk);
    chk("channel reset end", 0, o_channel_reset);
    apb(0, 12'h004, 0);
    chk("status", 32'h0000_0009, rd);
    chk("ten bit", 1, o_ten_bit);
    apb(1, 12'h004, 32'h0000_0001);
    @(negedge i_mclk);
    chk("locked cleared", 0, o_locked_write_q);
    $display("test interlock done");
    stop_test;
  end
endmodule // video_display_control_decode_test
